// ==== ptss_pkg.sv ====
package ptss_pkg;

    // Transmit modes handed down by PHY control.
    typedef enum logic [1:0]
    {
        PTSS_SEND_N,
        PTSS_SEND_I,
        PTSS_SEND_Z
    } ptss_mode_t;

    // Symbol row chosen for each symbol period.
    typedef enum logic [3:0]
    {
        PTSS_SYM_IDLE,
        PTSS_SYM_ZERO,
        PTSS_SYM_SSD1,
        PTSS_SYM_SSD2,
        PTSS_SYM_DATA,
        PTSS_SYM_XMT_ERR,
        PTSS_SYM_CSRESET,
        PTSS_SYM_CSEXTEND,
        PTSS_SYM_CSEXTEND_ERR,
        PTSS_SYM_ESD1,
        PTSS_SYM_ESD_EXT_ERR,
        PTSS_SYM_ESD2_EXT0,
        PTSS_SYM_ESD2_EXT1,
        PTSS_SYM_ESD2_EXT2
    } ptss_sym_t;

    // Register map, byte addresses.
    localparam logic [7:0]  PTSS_ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  PTSS_ADDR_SEED   = 8'h04;
    localparam logic [7:0]  PTSS_ADDR_STATUS = 8'h08;

    // Field positions.
    localparam int          PTSS_CTRL_LOAD_BIT  = 0;
    localparam int          PTSS_STAT_SYM_LSB   = 0;
    localparam int          PTSS_STAT_MASTER    = 4;
    localparam int          PTSS_STAT_LPI       = 5;
    localparam int          PTSS_STAT_LATCH     = 6;

    // Scrambler geometry and reset values.
    localparam int          PTSS_SCR_LEN        = 33;
    localparam int          PTSS_TAP_MASTER     = 12;
    localparam int          PTSS_TAP_SLAVE      = 19;
    localparam logic [31:0] PTSS_SEED_RESET     = 32'h0000_0001;
    localparam logic [32:0] PTSS_SCR_RESET      = 33'h1_0000_0001;

    // Carrier extension data value.
    localparam logic [7:0]  PTSS_TXD_EXTEND     = 8'h0F;
    localparam int          PTSS_HIST_DEPTH     = 4;

endpackage : ptss_pkg

// ==== ptss_scrambler.sv ====
`timescale 1ns/1ps
module ptss_scrambler
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        master_i,
    input  wire logic        load_i,
    input  wire logic [31:0] seed_i,
    output logic      [32:0] state_o
);

    logic [32:0] scr_reg;
    logic [32:0] scr_next;
    wire         fb_master = scr_reg[ptss_pkg::PTSS_TAP_MASTER] ^ scr_reg[32];
    wire         fb_slave  = scr_reg[ptss_pkg::PTSS_TAP_SLAVE] ^ scr_reg[32];
    wire         fb        = master_i ? fb_master : fb_slave;

    ////////////////////////////////////////////////////////////////////////////
    // A seed load forces the top bit high, so the state can never be all zeros.
    assign scr_next = load_i ? {1'b1, seed_i} : {scr_reg[31:0], fb};

    // The shift register advances once per symbol period.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            scr_reg <= ptss_pkg::PTSS_SCR_RESET;
        else
            scr_reg <= scr_next;
    end

    assign state_o = scr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // An attempt launched on the edge that still sees reset low is skipped, because
    // the state after that edge is the reset value and not a shifted one.
    a_scr_master: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rst_n_i && master_i && !load_i |=> scr_reg[0] == $past(fb_master))
        else $error("Master scrambler feedback wrong.");
    a_scr_slave: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rst_n_i && !master_i && !load_i |=> scr_reg[0] == $past(fb_slave))
        else $error("Slave scrambler feedback wrong.");
    a_scr_nonzero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        scr_reg != 33'h0_0000_0000)
        else $error("Scrambler state went all zero.");

endmodule : ptss_scrambler

// ==== pcs_tx_symbol_substitution.sv ====
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - The symbol row emitted each period follows the transmit mode from PHY control.
// - In MASTER configuration the scrambler runs on the MASTER feedback polynomial.
// - In SLAVE configuration the scrambler runs on the SLAVE feedback polynomial.
// - The scrambler state is never loaded or left at all zeros.
// - An error with enable high now and in each of the two periods before sends the transmit-error row.
// - An encoder reset period without error sends the normal reset row.
// - An encoder reset period with error sends the extend row for 0x0F, else extend-error.
// - Extend-error in the first reset octet is carried into the second and both ESD octets.
// - Extend-error during the end delimiter sends the extend-error delimiter row.
// - Without energy-efficient support the local low-power request always reads false.
module pcs_tx_symbol_substitution
(
    input  wire logic                 CLK_SYS_I,
    input  wire logic                 RST_N_I,
    input  wire logic [7:0]           TXD_I,
    input  wire logic                 TX_ENABLE_I,
    input  wire logic                 TX_ERROR_I,
    input  wire ptss_pkg::ptss_mode_t TX_MODE_I,
    input  wire logic                 CONFIG_MASTER_I,
    input  wire logic [7:0]           REG_ADDR_I,
    input  wire logic [31:0]          REG_WDATA_I,
    input  wire logic                 REG_WR_I,
    input  wire logic                 REG_RD_I,
    output logic      [31:0]          REG_RDATA_O,
    output ptss_pkg::ptss_sym_t       SYM_CLASS_O,
    output logic      [7:0]           SD_O,
    output logic                      LOC_LPI_REQ_O
);

    localparam int D = ptss_pkg::PTSS_HIST_DEPTH;

    logic [D:1]          en_hist_reg;
    logic [D:1]          err_hist_reg;
    logic                latch_reg;
    logic                latch_next;
    logic [31:0]         seed_reg;
    logic [31:0]         rdata_next;
    logic [32:0]         scr_state;
    ptss_pkg::ptss_sym_t sym_reg;
    ptss_pkg::ptss_sym_t sym_next;
    ptss_pkg::ptss_sym_t esd2_sym;
    logic [7:0]          sd_next;

    ////////////////////////////////////////////////////////////////////////////
    // Register decode.
    wire wr_ctrl   = REG_WR_I && (REG_ADDR_I == ptss_pkg::PTSS_ADDR_CTRL);
    wire wr_seed   = REG_WR_I && (REG_ADDR_I == ptss_pkg::PTSS_ADDR_SEED);
    wire seed_load = wr_ctrl && REG_WDATA_I[ptss_pkg::PTSS_CTRL_LOAD_BIT];

    // Reads of unmapped addresses return zero.
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (REG_RD_I)
        begin
            case (REG_ADDR_I)
                ptss_pkg::PTSS_ADDR_SEED:
                    rdata_next = seed_reg;
                ptss_pkg::PTSS_ADDR_STATUS:
                begin
                    rdata_next[ptss_pkg::PTSS_STAT_SYM_LSB +: 4] = sym_reg;
                    rdata_next[ptss_pkg::PTSS_STAT_MASTER]       = CONFIG_MASTER_I;
                    rdata_next[ptss_pkg::PTSS_STAT_LPI]          = LOC_LPI_REQ_O;
                    rdata_next[ptss_pkg::PTSS_STAT_LATCH]        = latch_reg;
                end
                default:
                    rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // The seed lives here; a CTRL write with the load bit set then moves it into the scrambler.
    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
            seed_reg <= ptss_pkg::PTSS_SEED_RESET;
        else if (wr_seed)
            seed_reg <= REG_WDATA_I;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Side-stream scrambler; polynomial picked by the configuration input.
    ptss_scrambler u_scrambler
    (
        .clk_i    (CLK_SYS_I),
        .rst_n_i  (RST_N_I),
        .master_i (CONFIG_MASTER_I),
        .load_i   (seed_load),
        .seed_i   (seed_reg),
        .state_o  (scr_state)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Enable and error history, index k holding period n-k.
    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
        begin
            en_hist_reg  <= '0;
            err_hist_reg <= '0;
        end
        else
        begin
            en_hist_reg  <= {en_hist_reg[D-1:1], TX_ENABLE_I};
            err_hist_reg <= {err_hist_reg[D-1:1], TX_ERROR_I};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame position terms from the history.
    wire en0      = TX_ENABLE_I;
    wire normal   = (TX_MODE_I == ptss_pkg::PTSS_SEND_N);
    wire csreset  = en_hist_reg[2] && !en0;
    wire first_cs = csreset && en_hist_reg[1];
    wire ssd1     = en0 && !en_hist_reg[1];
    wire ssd2     = en_hist_reg[1] && !en_hist_reg[2];
    wire esd1     = !en_hist_reg[2] && en_hist_reg[3];
    wire esd2     = !en_hist_reg[3] && en_hist_reg[4];
    wire txd_ext  = (TXD_I == ptss_pkg::PTSS_TXD_EXTEND);
    wire ext_err  = TX_ERROR_I && !txd_ext;
    wire err_all  = TX_ERROR_I && (&err_hist_reg[3:1]);

    // The carried error is set in the first reset octet and dies after ESD2.
    // Setting wins over clearing so a new frame tail is never missed.
    always_comb
    begin
        latch_next = latch_reg;
        if (esd2 || en0 || !normal)
            latch_next = 1'b0;
        if (normal && first_cs && ext_err)
            latch_next = 1'b1;
    end

    // Second end-delimiter octet, error rows taking precedence.
    always_comb
    begin
        if (latch_reg || ext_err)
            esd2_sym = ptss_pkg::PTSS_SYM_ESD_EXT_ERR;
        else if (!TX_ERROR_I && !err_hist_reg[1])
            esd2_sym = ptss_pkg::PTSS_SYM_ESD2_EXT0;
        else if (!TX_ERROR_I && (&err_hist_reg[3:1]))
            esd2_sym = ptss_pkg::PTSS_SYM_ESD2_EXT1;
        else if (err_all && txd_ext)
            esd2_sym = ptss_pkg::PTSS_SYM_ESD2_EXT2;
        else
            esd2_sym = ptss_pkg::PTSS_SYM_ESD_EXT_ERR;
    end

    // Symbol row selection; substitution rows ignore the scrambled bits.
    always_comb
    begin
        sym_next = ptss_pkg::PTSS_SYM_IDLE;
        case (TX_MODE_I)
            ptss_pkg::PTSS_SEND_Z:
                sym_next = ptss_pkg::PTSS_SYM_ZERO;
            ptss_pkg::PTSS_SEND_I:
                sym_next = ptss_pkg::PTSS_SYM_IDLE;
            ptss_pkg::PTSS_SEND_N:
            begin
                if (csreset && (latch_reg || (TX_ERROR_I && !txd_ext)))
                    sym_next = ptss_pkg::PTSS_SYM_CSEXTEND_ERR;
                else if (csreset && TX_ERROR_I)
                    sym_next = ptss_pkg::PTSS_SYM_CSEXTEND;
                else if (csreset)
                    sym_next = ptss_pkg::PTSS_SYM_CSRESET;
                else if (ssd1)
                    sym_next = ptss_pkg::PTSS_SYM_SSD1;
                else if (ssd2)
                    sym_next = ptss_pkg::PTSS_SYM_SSD2;
                else if (en0 && en_hist_reg[2] && TX_ERROR_I)
                    sym_next = ptss_pkg::PTSS_SYM_XMT_ERR;
                else if (en0)
                    sym_next = ptss_pkg::PTSS_SYM_DATA;
                else if (esd1 && (latch_reg || ext_err))
                    sym_next = ptss_pkg::PTSS_SYM_ESD_EXT_ERR;
                else if (esd1)
                    sym_next = ptss_pkg::PTSS_SYM_ESD1;
                else if (esd2)
                    sym_next = esd2_sym;
                else
                    sym_next = ptss_pkg::PTSS_SYM_IDLE;
            end
            default:
                sym_next = ptss_pkg::PTSS_SYM_IDLE;
        endcase
    end

    // Scrambled data only in data periods, plain scrambler bits in idle.
    assign sd_next = (sym_next == ptss_pkg::PTSS_SYM_DATA) ? (TXD_I ^ scr_state[7:0]) :
                     (sym_next == ptss_pkg::PTSS_SYM_IDLE) ? scr_state[7:0] : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Output registers; the low-power request is held false, no EEE support.
    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
        begin
            sym_reg       <= ptss_pkg::PTSS_SYM_IDLE;
            SD_O          <= 8'h00;
            latch_reg     <= 1'b0;
            REG_RDATA_O   <= 32'h0000_0000;
            LOC_LPI_REQ_O <= 1'b0;
        end
        else
        begin
            sym_reg       <= sym_next;
            SD_O          <= sd_next;
            latch_reg     <= latch_next;
            REG_RDATA_O   <= rdata_next;
            LOC_LPI_REQ_O <= 1'b0;
        end
    end

    assign SYM_CLASS_O = sym_reg;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_first_ext;
        normal && first_cs && ext_err;
    endsequence
    sequence s_quiet;
        normal && !TX_ENABLE_I;
    endsequence

    a_zero_mode: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        TX_MODE_I == ptss_pkg::PTSS_SEND_Z |=> SYM_CLASS_O == ptss_pkg::PTSS_SYM_ZERO)
        else $error("Zero mode did not send zeros.");
    a_xmt_err_row: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        normal && TX_ENABLE_I && $past(TX_ENABLE_I, 2) && $past(TX_ENABLE_I) && TX_ERROR_I
        |=> SYM_CLASS_O == ptss_pkg::PTSS_SYM_XMT_ERR && SD_O == 8'h00)
        else $error("Transmit error row missing.");
    a_csreset_row: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        normal && csreset && !TX_ERROR_I && !latch_reg
        |=> SYM_CLASS_O == ptss_pkg::PTSS_SYM_CSRESET)
        else $error("Normal reset row missing.");
    a_csextend_row: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        normal && csreset && TX_ERROR_I && !latch_reg
        |=> SYM_CLASS_O == ($past(TXD_I) == 8'h0F ? ptss_pkg::PTSS_SYM_CSEXTEND
                                                   : ptss_pkg::PTSS_SYM_CSEXTEND_ERR))
        else $error("Extend row wrong.");
    a_ext_carry: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        s_first_ext ##1 s_quiet[*3]
        |-> ($past(SYM_CLASS_O) == ptss_pkg::PTSS_SYM_CSEXTEND_ERR
             && SYM_CLASS_O == ptss_pkg::PTSS_SYM_ESD_EXT_ERR)
        ##1 (SYM_CLASS_O == ptss_pkg::PTSS_SYM_ESD_EXT_ERR))
        else $error("Carried extend error lost.");
    a_esd_ext_err: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        normal && esd1 && ext_err |=> SYM_CLASS_O == ptss_pkg::PTSS_SYM_ESD_EXT_ERR)
        else $error("Extend error delimiter missing.");
    a_lpi_false: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        ##1 !LOC_LPI_REQ_O)
        else $error("Low-power request raised.");
    // The edge that still samples reset low clears the history, so it starts no attempt.
    a_hist_depth: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        RST_N_I |-> ##4 (en_hist_reg[4] == $past(TX_ENABLE_I, 4)
                         && err_hist_reg[4] == $past(TX_ERROR_I, 4)))
        else $error("History depth wrong.");

endmodule : pcs_tx_symbol_substitution

// ==== ptss_gmii_src.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Reconciliation side of the transmit lane: one octet and its flags per period.
module ptss_gmii_src
(
    input  wire logic            clk_i,
    input  wire logic [19:0]     row_i,
    output logic      [7:0]      txd_o,
    output logic                 en_o,
    output logic                 err_o,
    output ptss_pkg::ptss_mode_t mode_o
);
    logic [7:0] junk_reg = 8'hA5;

    ////////////////////////////////////////////////////////////////////////////
    // Outside a frame or an extension the data lane carries nothing defined,
    // so it churns every cycle; the coder must never lean on a stale octet.
    always_ff @(posedge clk_i)
    begin
        junk_reg <= ~junk_reg + 8'h3B;
    end

    // Row layout: mode in [17:16], enable [13], error [12], octet [11:4].
    assign en_o   = row_i[13];
    assign err_o  = row_i[12];
    assign mode_o = ptss_pkg::ptss_mode_t'(row_i[17:16]);
    assign txd_o  = (en_o | err_o) ? row_i[11:4] : junk_reg;
endmodule : ptss_gmii_src

// ==== pcs_tx_symbol_substitution_tb.sv ====
`timescale 1ns/1ps
module pcs_tx_symbol_substitution_tb;
    logic                 clk   = 1'b0;
    logic                 rst_n = 1'b0;
    logic [19:0]          row   = 20'h00000;
    logic                 cfg_m = 1'b1;
    logic [7:0]           addr  = 8'h00;
    logic [31:0]          wdata = 32'h0;
    logic                 wr    = 1'b0;
    logic                 rd    = 1'b0;
    logic [31:0]          rdata;
    logic [7:0]           txd;
    logic [7:0]           sd;
    logic                 en;
    logic                 err;
    logic                 lpi;
    logic [3:0]           e;
    ptss_pkg::ptss_mode_t mode;
    ptss_pkg::ptss_sym_t  sym;
    int                   n_errors = 0;
    int                   samples_checked = 0;
    int                   cyc = 0;
    logic [7:0]           smp [0:9];
    // Rows are 20'hMETTX: mode, {enable,error}, octet, expected symbol row.
    logic [19:0]          tbl [0:44] = '{
        20'h20001, 20'h10000, 20'h00000, 20'h02552, 20'h02663, 20'h02774,
        20'h03885, 20'h00006, 20'h00006, 20'h00009, 20'h0000B, 20'h00000,
        20'h02112, 20'h02223, 20'h02334, 20'h010F7, 20'h010F7, 20'h010F9,
        20'h0000C, 20'h00000, 20'h02112, 20'h02223, 20'h02334, 20'h010F7,
        20'h010F7, 20'h010F9, 20'h010FD, 20'h00000, 20'h02112, 20'h02223,
        20'h02334, 20'h01338, 20'h00008, 20'h0000A, 20'h0000A, 20'h00000,
        20'h02112, 20'h02223, 20'h02334, 20'h00006, 20'h00006, 20'h0144A,
        20'h0000A, 20'h00000, 20'h00000};

    ////////////////////////////////////////////////////////////////////////////
    // Clock of 50 ns; a hung run is cut off at 2000 cycles, far beyond the 120 or so cycles used.
    always #25 clk = ~clk;

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_errors++;
            end_sim();
        end
    end

    ptss_gmii_src i_src (.clk_i(clk), .row_i(row), .txd_o(txd), .en_o(en), .err_o(err),
                         .mode_o(mode));

    pcs_tx_symbol_substitution i_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .TXD_I(txd),
        .TX_ENABLE_I(en), .TX_ERROR_I(err), .TX_MODE_I(mode), .CONFIG_MASTER_I(cfg_m),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .SYM_CLASS_O(sym), .SD_O(sd), .LOC_LPI_REQ_O(lpi));

    ////////////////////////////////////////////////////////////////////////////
    // Compare tasks, register bus tasks and the closing report.
    task automatic chk_sym(input string nm, input ptss_pkg::ptss_sym_t x);
        samples_checked++;
        if (sym !== x)
        begin
            n_errors++;
            $display("[ERR] %s expected %0d seen %0d", nm, x, sym);
        end
    endtask : chk_sym

    task automatic chk_v(input string nm, input logic [31:0] x, input logic [31:0] v);
        samples_checked++;
        if (v !== x)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, x, v);
        end
    endtask : chk_v

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : reg_wr

    // Read data stand only in the cycle after the read edge, so look mid-cycle there.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input string nm);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        chk_v(nm, x, rdata);
    endtask : rd_chk

    // Load a seed, then match idle output against a software scrambler at a few
    // alignments; the wrong polynomial cannot line up over ten octets, save from a zero seed.
    task automatic scr_chk(input logic m, input logic [31:0] s);
        logic [32:0] st;
        logic [7:0]  seq [0:13];
        logic        ok;
        int          hits;
        @(posedge clk);
        cfg_m <= m;
        reg_wr(ptss_pkg::PTSS_ADDR_SEED, s);
        reg_wr(ptss_pkg::PTSS_ADDR_CTRL, 32'h1);
        // The octet registered on the load edge still comes from the old state.
        @(negedge clk);
        for (int i = 0; i < 10; i++)
        begin
            @(negedge clk);
            smp[i] = sd;
        end
        st = {1'b1, s};
        for (int i = 0; i < 14; i++)
        begin
            seq[i] = st[7:0];
            st = {st[31:0], st[m ? 12 : 19] ^ st[32]};
        end
        hits = 0;
        for (int k = 0; k < 4; k++)
        begin
            ok = 1'b1;
            for (int i = 0; i < 10; i++)
                ok &= (smp[i] === seq[k + i]);
            hits += ok;
        end
        chk_v("scrambler sequence", 32'h1, {31'h0, hits != 0});
    endtask : scr_chk

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////////
    // Reset, registers, the row table, scrambler cases, then a reset inside a frame.
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_sym("sym after reset", ptss_pkg::PTSS_SYM_IDLE);
        chk_v("lpi after reset", 32'h0, {31'h0, lpi});
        rd_chk(ptss_pkg::PTSS_ADDR_SEED, 32'h1, "seed reset");
        rd_chk(ptss_pkg::PTSS_ADDR_CTRL, 32'h0, "ctrl read");
        rd_chk(ptss_pkg::PTSS_ADDR_STATUS, 32'h1 << ptss_pkg::PTSS_STAT_MASTER, "status");
        reg_wr(8'h0C, 32'hFFFF_FFFF);
        rd_chk(8'h0C, 32'h0, "unmapped");
        reg_wr(ptss_pkg::PTSS_ADDR_SEED, 32'hA5A5_5A5A);
        rd_chk(ptss_pkg::PTSS_ADDR_SEED, 32'hA5A5_5A5A, "seed readback");
        for (int i = 0; i < 45; i++)
        begin
            @(posedge clk);
            row <= tbl[i];
            @(negedge clk);
            if (i > 0)
            begin
                e = tbl[i - 1][3:0];
                chk_sym("symbol row", ptss_pkg::ptss_sym_t'(e));
                if (e != 4'h0 && e != 4'h4)
                    chk_v("substituted sd", 32'h0, {24'h0, sd});
                chk_v("lpi request", 32'h0, {31'h0, lpi});
            end
        end
        scr_chk(1'b1, 32'h1234_5678);
        scr_chk(1'b0, 32'h1234_5678);
        scr_chk(1'b1, 32'h0000_0000);
        @(posedge clk);
        row <= 20'h02112;
        repeat (2) @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk_sym("sym in reset", ptss_pkg::PTSS_SYM_IDLE);
        @(negedge clk);
        chk_sym("restart after reset", ptss_pkg::PTSS_SYM_SSD1);
        rd_chk(ptss_pkg::PTSS_ADDR_SEED, 32'h1, "seed after reset");
        end_sim();
    end
endmodule : pcs_tx_symbol_substitution_tb
